// >>> rtl/sfr_pkg.sv
// Shared constants and types for the flash power, reset and rescue link
package sfr_pkg;
	localparam int unsigned SYS_CLK_HZ = 40_000_000;
	localparam int unsigned CLK_PERIOD_NS = 25;
	// Power-up access wait, microseconds
	localparam int unsigned POWER_TO_FULL_ACCESS_US = 150;
	localparam int unsigned POWER_TO_FULL_ACCESS_CYC =
		POWER_TO_FULL_ACCESS_US * (SYS_CLK_HZ / 1_000_000);
	// Rescue gap between selections, nanoseconds, rounded up
	localparam int unsigned RESCUE_DESELECT_GAP_NS = 50;
	localparam int unsigned RESCUE_DESELECT_GAP_CYC =
		(RESCUE_DESELECT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Hardware reset pulse width, nanoseconds, rounded up
	localparam int unsigned HW_RESET_LOW_WIDTH_NS = 50;
	localparam int unsigned HW_RESET_LOW_WIDTH_CYC =
		(HW_RESET_LOW_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Recovery after hardware reset: short and long, rounded down
	localparam int unsigned HW_RESET_RECOVERY_SHORT_NS = 40;
	localparam int unsigned HW_RESET_RECOVERY_SHORT_CYC =
		(HW_RESET_RECOVERY_SHORT_NS / CLK_PERIOD_NS) < 1 ? 1 :
		HW_RESET_RECOVERY_SHORT_NS / CLK_PERIOD_NS;
	localparam int unsigned RESET_RECOVERY_LONG_US = 30;
	localparam int unsigned RESET_RECOVERY_LONG_CYC =
		RESET_RECOVERY_LONG_US * (SYS_CLK_HZ / 1_000_000);
	// Recovery after software reset from standby, rounded down
	localparam int unsigned SOFT_RESET_RECOVERY_NS = 90;
	localparam int unsigned SOFT_RESET_RECOVERY_CYC = SOFT_RESET_RECOVERY_NS / CLK_PERIOD_NS;
	// Rescue clock counts per selection
	localparam logic [4:0] RESCUE_CNT_A = 5'h07;
	localparam logic [4:0] RESCUE_CNT_B = 5'h0d;
	localparam logic [4:0] RESCUE_CNT_C = 5'h19;
	localparam logic [4:0] RESCUE_CNT_FF = 5'h08;
	// Command codes; only the two status reads are kept open during power-up
	localparam logic [7:0] CMD_READ_STATUS = 8'h05;
	localparam logic [7:0] CMD_READ_FLAG_STATUS = 8'h70;
	localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
	localparam logic [7:0] CMD_RESET_MEMORY = 8'h99;
	localparam logic [7:0] CMD_FAST_READ = 8'h0b;
	localparam int unsigned WAIT_W = 16;
	// Serial protocol modes
	typedef enum logic [2:0] {
		SFR_PROTO_EXT = 3'b001,
		SFR_PROTO_DUAL = 3'b010,
		SFR_PROTO_QUAD = 3'b100
	} sfr_proto_t;
endpackage : sfr_pkg

// >>> rtl/sfr_link_if.sv
// Link wires between the flash end and the host end
interface sfr_link_if;
	logic sclk;
	logic sel_n;
	logic hw_reset_n;
	logic io_line_zero;
	logic io_line_three_hold;
	logic io_line_one;
	logic io_line_one_oe;
	modport flash_end (
		input sclk,
		input sel_n,
		input hw_reset_n,
		input io_line_zero,
		input io_line_three_hold,
		output io_line_one,
		output io_line_one_oe
	);
	modport host_end (
		output sclk,
		output sel_n,
		output hw_reset_n,
		output io_line_zero,
		output io_line_three_hold,
		input io_line_one,
		input io_line_one_oe
	);
endinterface : sfr_link_if

// >>> rtl/sfr_flash_end.sv
// Flash end: power-on hold-off, restricted commands, rescue and reset recovery
module sfr_flash_end #(
	parameter int unsigned POWER_WAIT_CYC = sfr_pkg::POWER_TO_FULL_ACCESS_CYC,
	parameter int unsigned LONG_WAIT_CYC = sfr_pkg::RESET_RECOVERY_LONG_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	sfr_link_if.flash_end link,
	input wire logic supply_ok,
	input wire logic boot_xip,
	input wire logic boot_proto_dual,
	input wire logic array_busy,
	input wire logic deep_power_down,
	output logic power_on_complete,
	output logic ready,
	output logic in_xip,
	output logic proto_ext,
	output logic write_enable_latch,
	output logic write_in_progress,
	output logic lock_write_bit,
	output logic lock_down_bit,
	output logic [7:0] last_cmd,
	output logic cmd_strobe,
	output logic rescue_done
);
	import sfr_pkg::*;

	typedef enum logic [3:0] {
		RS_P1A = 4'b0001,
		RS_P1B = 4'b0010,
		RS_P1C = 4'b0100,
		RS_P2 = 4'b1000
	} sfr_rescue_t;

	typedef struct packed {
		logic [1:0] sclk_s;
		logic [1:0] sel_s;
		logic [1:0] rst_s;
		logic [1:0] d0_s;
		logic [1:0] d3_s;
		logic [1:0] sup_s;
		logic sclk_d;
		logic sel_d;
		logic rst_d;
		logic powered;
		logic [WAIT_W-1:0] pwr_cnt;
		logic poc;
		logic [WAIT_W-1:0] busy_cnt;
		logic [4:0] clk_cnt;
		logic all_ones;
		sfr_rescue_t rstate;
		logic execute_in_place_mode;
		sfr_proto_t proto;
		logic [7:0] shift;
		logic [7:0] cmd;
		logic strobe;
		logic rst_en;
		logic wel;
		logic wip;
		logic lock_w;
		logic lock_d;
		logic done;
		logic rdy;
		logic ext;
	} sfr_flash_st_t;

	sfr_flash_st_t st_reg;
	sfr_flash_st_t st_next;
	logic sclk_rise;
	logic sel_fall;
	logic sel_rise;
	logic rst_rise;
	logic cmd_allowed;
	logic [WAIT_W-1:0] recov;
	logic [7:0] shift_in;

	// Only the second flop of each synchroniser is looked at
	assign sclk_rise = st_reg.sclk_s[1] & ~st_reg.sclk_d;
	assign sel_fall = ~st_reg.sel_s[1] & st_reg.sel_d;
	assign sel_rise = st_reg.sel_s[1] & ~st_reg.sel_d;
	assign rst_rise = st_reg.rst_s[1] & ~st_reg.rst_d;
	// Byte as it stands once this clock's bit is in; avoids a loop through st_next
	assign shift_in = {st_reg.shift[6:0], st_reg.d0_s[1]};
	// Status reads pass even before power-on completes
	assign cmd_allowed = st_reg.poc
		|| (shift_in == CMD_READ_STATUS)
		|| (shift_in == CMD_READ_FLAG_STATUS);
	// Long wait from deep power-down or array work, else short
	// Slow register writes and erases count as array work here
	assign recov = (deep_power_down || array_busy) ? WAIT_W'(LONG_WAIT_CYC)
		: WAIT_W'(HW_RESET_RECOVERY_SHORT_CYC);

	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.sclk_s = {st_reg.sclk_s[0], link.sclk};
		st_next.sel_s = {st_reg.sel_s[0], link.sel_n};
		st_next.rst_s = {st_reg.rst_s[0], link.hw_reset_n};
		st_next.d0_s = {st_reg.d0_s[0], link.io_line_zero};
		st_next.d3_s = {st_reg.d3_s[0], link.io_line_three_hold};
		st_next.sup_s = {st_reg.sup_s[0], supply_ok};
		st_next.sclk_d = st_reg.sclk_s[1];
		st_next.sel_d = st_reg.sel_s[1];
		st_next.rst_d = st_reg.rst_s[1];
		st_next.strobe = 1'b0;
		if (st_reg.busy_cnt != '0) begin
			st_next.busy_cnt = st_reg.busy_cnt - WAIT_W'(1);
		end
		if (!st_reg.sup_s[1]) begin
			// Supply low: state cleared except clock, select, reset and supply synchronisers; nothing decoded
			st_next = '0;
			st_next.sclk_s = {st_reg.sclk_s[0], link.sclk};
			st_next.sel_s = {st_reg.sel_s[0], link.sel_n};
			st_next.rst_s = {st_reg.rst_s[0], link.hw_reset_n};
			st_next.sup_s = {st_reg.sup_s[0], supply_ok};
			st_next.rstate = RS_P1A;
			st_next.proto = SFR_PROTO_EXT;
		end else if (!st_reg.powered) begin
			// Power just settled: load boot state, start access timer
			st_next.powered = 1'b1;
			st_next.pwr_cnt = WAIT_W'(POWER_WAIT_CYC);
			st_next.execute_in_place_mode = boot_xip;
			st_next.proto = boot_proto_dual ? SFR_PROTO_DUAL : SFR_PROTO_EXT;
			st_next.wel = 1'b0;
			st_next.wip = 1'b0;
			st_next.lock_w = 1'b0;
			st_next.lock_d = 1'b0;
		end else if (!st_reg.rst_s[1]) begin
			// Hardware reset held: abort frame, drop execute-in-place
			st_next.clk_cnt = '0;
			st_next.execute_in_place_mode = 1'b0;
			st_next.wel = 1'b0;
			st_next.rst_en = 1'b0;
		end else begin
			if (st_reg.pwr_cnt != '0) begin
				st_next.pwr_cnt = st_reg.pwr_cnt - WAIT_W'(1);
			end else begin
				st_next.poc = 1'b1;
			end
			if (rst_rise) begin
				st_next.busy_cnt = recov;
			end
			if (sel_fall) begin
				st_next.clk_cnt = '0;
				st_next.all_ones = 1'b1;
				st_next.shift = '0;
			end
			if (!st_reg.sel_s[1] && sclk_rise) begin
				st_next.clk_cnt = st_reg.clk_cnt + 5'h01;
				st_next.all_ones = st_reg.all_ones & st_reg.d0_s[1] & st_reg.d3_s[1];
				st_next.shift = {st_reg.shift[6:0], st_reg.d0_s[1]};
				// First dummy clock after fast read carries confirmation bit
				if (st_reg.execute_in_place_mode && st_reg.cmd == CMD_FAST_READ && st_reg.clk_cnt == RESCUE_CNT_FF
						&& st_reg.d0_s[1]) begin
					st_next.execute_in_place_mode = 1'b0;
				end
				if (st_next.clk_cnt == RESCUE_CNT_FF && st_reg.busy_cnt == '0
						&& cmd_allowed) begin
					st_next.cmd = st_next.shift;
					st_next.strobe = 1'b1;
					// Software reset needs the enable first
					if (st_next.shift == CMD_RESET_MEMORY && st_reg.rst_en) begin
						st_next.busy_cnt = deep_power_down || array_busy
							? WAIT_W'(LONG_WAIT_CYC) : WAIT_W'(SOFT_RESET_RECOVERY_CYC);
						st_next.execute_in_place_mode = 1'b0;
						st_next.wel = 1'b0;
					end
					st_next.rst_en = (st_next.shift == CMD_RESET_ENABLE);
				end
			end
			if (sel_rise) begin
				// Rescue sequence watcher, counts clocks of all-ones frames
				if (!st_reg.all_ones) begin
					st_next.rstate = RS_P1A;
				end else begin
					case (st_reg.rstate)
						RS_P1A: begin
							st_next.rstate = st_reg.clk_cnt == RESCUE_CNT_A ? RS_P1B : RS_P1A;
						end
						RS_P1B: begin
							st_next.rstate = st_reg.clk_cnt == RESCUE_CNT_B ? RS_P1C : RS_P1A;
						end
						RS_P1C: begin
							st_next.rstate = st_reg.clk_cnt == RESCUE_CNT_C ? RS_P2 : RS_P1A;
						end
						RS_P2: begin
							st_next.rstate = RS_P1A;
							if (st_reg.clk_cnt == RESCUE_CNT_FF) begin
								st_next.proto = SFR_PROTO_EXT;
								st_next.execute_in_place_mode = 1'b0;
								st_next.done = 1'b1;
							end
						end
						default: begin
							st_next.rstate = RS_P1A;
						end
					endcase
				end
			end
		end
		// Registered copies keep these outputs straight from flops
		st_next.rdy = st_next.poc && (st_next.busy_cnt == '0);
		st_next.ext = (st_next.proto == SFR_PROTO_EXT);
	end

	// State register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '{rstate: RS_P1A, proto: SFR_PROTO_EXT, ext: 1'b1, sel_s: 2'b11, sel_d: 1'b1,
				rst_s: 2'b11, rst_d: 1'b1, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs come from the state flops; line one not driven here
	assign power_on_complete = st_reg.poc;
	assign ready = st_reg.rdy;
	assign in_xip = st_reg.execute_in_place_mode;
	assign proto_ext = st_reg.ext;
	assign write_enable_latch = st_reg.wel;
	assign write_in_progress = st_reg.wip;
	assign lock_write_bit = st_reg.lock_w;
	assign lock_down_bit = st_reg.lock_d;
	assign last_cmd = st_reg.cmd;
	assign cmd_strobe = st_reg.strobe;
	assign rescue_done = st_reg.done;
	assign link.io_line_one = 1'b0;
	assign link.io_line_one_oe = 1'b0;
endmodule : sfr_flash_end

// >>> rtl/sfr_host_end.sv
// Host end: rescue sequencer, hardware reset pulse and command byte sender
module sfr_host_end #(
	parameter int unsigned CLK_DIV = 4
) (
	input wire logic sys_clk,
	input wire logic rstn,
	sfr_link_if.host_end link,
	input wire logic supply_ok,
	input wire logic rescue_start,
	input wire logic hw_reset_start,
	input wire logic cmd_start,
	input wire logic [7:0] cmd_byte,
	output logic busy,
	output logic done
);
	import sfr_pkg::*;

	typedef enum logic [5:0] {
		HS_IDLE = 6'b000001,
		HS_GAP = 6'b000010,
		HS_CLK_LO = 6'b000100,
		HS_CLK_HI = 6'b001000,
		HS_RST = 6'b010000,
		HS_DONE = 6'b100000
	} sfr_host_st_t;

	typedef struct packed {
		sfr_host_st_t state;
		logic [1:0] sup_s;
		logic [2:0] step;
		logic rescue;
		logic [4:0] clk_cnt;
		logic [4:0] clk_tgt;
		logic [7:0] div;
		logic [7:0] gap;
		logic [7:0] data;
		logic sclk;
		logic sel_n;
		logic rst_n;
		logic d0;
		logic busy;
		logic done;
	} sfr_host_reg_t;

	sfr_host_reg_t st_reg;
	sfr_host_reg_t st_next;

	// Clock count for each rescue step
	function automatic logic [4:0] step_count(input logic [2:0] s);
		case (s)
			3'h0: step_count = RESCUE_CNT_A;
			3'h1: step_count = RESCUE_CNT_B;
			3'h2: step_count = RESCUE_CNT_C;
			default: step_count = RESCUE_CNT_FF;
		endcase
	endfunction : step_count

	// Sequencer
	always_comb begin
		st_next = st_reg;
		st_next.sup_s = {st_reg.sup_s[0], supply_ok};
		st_next.done = 1'b0;
		case (st_reg.state)
			HS_IDLE: begin
				st_next.sel_n = 1'b1;
				st_next.busy = 1'b0;
				if (st_reg.sup_s[1] && rescue_start) begin
					st_next.rescue = 1'b1;
					st_next.step = 3'h0;
					st_next.gap = 8'(RESCUE_DESELECT_GAP_CYC);
					st_next.state = HS_GAP;
					st_next.busy = 1'b1;
				end else if (hw_reset_start) begin
					st_next.rst_n = 1'b0;
					st_next.gap = 8'(HW_RESET_LOW_WIDTH_CYC);
					st_next.state = HS_RST;
					st_next.busy = 1'b1;
				end else if (st_reg.sup_s[1] && cmd_start) begin
					st_next.rescue = 1'b0;
					st_next.data = cmd_byte;
					st_next.gap = 8'(RESCUE_DESELECT_GAP_CYC);
					st_next.state = HS_GAP;
					st_next.busy = 1'b1;
				end
			end
			HS_GAP: begin
				// Deselect gap before every selection
				if (st_reg.gap != 8'h00) begin
					st_next.gap = st_reg.gap - 8'h01;
				end else begin
					st_next.sel_n = 1'b0;
					st_next.clk_cnt = 5'h00;
					st_next.clk_tgt = st_reg.rescue ? step_count(st_reg.step) : RESCUE_CNT_FF;
					st_next.d0 = st_reg.rescue ? 1'b1 : st_reg.data[7];
					st_next.div = 8'(CLK_DIV);
					st_next.state = HS_CLK_LO;
				end
			end
			HS_CLK_LO: begin
				if (st_reg.div != 8'h00) begin
					st_next.div = st_reg.div - 8'h01;
				end else if (st_reg.clk_cnt == st_reg.clk_tgt) begin
					// Deselect before the next clock edge
					st_next.sel_n = 1'b1;
					st_next.step = st_reg.step + 3'h1;
					st_next.gap = 8'(RESCUE_DESELECT_GAP_CYC);
					if (st_reg.rescue && st_reg.step != 3'h3) begin
						st_next.state = HS_GAP;
					end else begin
						st_next.state = HS_DONE;
					end
				end else begin
					st_next.sclk = 1'b1;
					st_next.div = 8'(CLK_DIV);
					st_next.clk_cnt = st_reg.clk_cnt + 5'h01;
					st_next.state = HS_CLK_HI;
				end
			end
			HS_CLK_HI: begin
				if (st_reg.div != 8'h00) begin
					st_next.div = st_reg.div - 8'h01;
				end else begin
					st_next.sclk = 1'b0;
					st_next.div = 8'(CLK_DIV);
					st_next.data = {st_reg.data[6:0], 1'b0};
					st_next.d0 = st_reg.rescue ? 1'b1 : st_reg.data[6];
					st_next.state = HS_CLK_LO;
				end
			end
			HS_RST: begin
				if (st_reg.gap != 8'h00) begin
					st_next.gap = st_reg.gap - 8'h01;
				end else begin
					st_next.rst_n = 1'b1;
					st_next.state = HS_DONE;
				end
			end
			HS_DONE: begin
				st_next.done = 1'b1;
				st_next.busy = 1'b0;
				st_next.state = HS_IDLE;
			end
			default: begin
				st_next.state = HS_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '{state: HS_IDLE, sel_n: 1'b1, rst_n: 1'b1, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	// Hold line three high throughout
	assign link.sclk = st_reg.sclk;
	assign link.sel_n = st_reg.sel_n;
	assign link.hw_reset_n = st_reg.rst_n;
	assign link.io_line_zero = st_reg.d0;
	assign link.io_line_three_hold = 1'b1;
	assign busy = st_reg.busy;
	assign done = st_reg.done;
endmodule : sfr_host_end

// >>> bench/sfr_link_asserts.sv
// Wire checker for the flash power, reset and rescue link
module sfr_link_asserts (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic supply_ok,
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic hw_reset_n,
	input wire logic io_line_zero,
	input wire logic io_line_three_hold,
	input wire logic io_line_one,
	input wire logic io_line_one_oe
);
	logic [5:0] clk_cnt;
	logic sclk_q;
	logic sel_q;
	// Clock rises per selection, kept through the deselect edge so it can be judged
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			clk_cnt <= 6'h00;
			sclk_q <= 1'b0;
			sel_q <= 1'b1;
		end else begin
			sclk_q <= sclk;
			sel_q <= sel_n;
			if (sclk && !sclk_q && !sel_n)
				clk_cnt <= clk_cnt + 6'h01;
			else if (sel_n && sel_q)
				clk_cnt <= 6'h00;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_frame_clock_count: assert property (
		$rose(sel_n) |-> clk_cnt inside {6'h07, 6'h0d, 6'h19, 6'h08})
		else $error("selection ended after an illegal clock count");
	a_select_power_low: assert property (!supply_ok |-> sel_n)
		else $error("device selected while supply low");
	a_deselect_gap: assert property ($rose(sel_n) |-> sel_n [*2])
		else $error("deselect gap shorter than two cycles");
	a_sclk_idle_low: assert property (sel_n |-> !sclk)
		else $error("serial clock high while deselected");
	a_sclk_high_width: assert property ($rose(sclk) |-> sclk [*5])
		else $error("serial clock high phase too short");
	a_sclk_low_width: assert property ($fell(sclk) |-> !sclk [*5])
		else $error("serial clock low phase too short");
	a_reset_pulse_width: assert property ($fell(hw_reset_n) |-> !hw_reset_n [*2])
		else $error("hardware reset pulse shorter than two cycles");
	a_reset_deselected: assert property (!hw_reset_n |-> sel_n)
		else $error("device selected during hardware reset");
	a_hold_line_high: assert property (!sel_n |-> io_line_three_hold)
		else $error("hold line low while selected");
endmodule : sfr_link_asserts

// >>> bench/tb_top.sv
// Testbench joining host end and flash end across the link
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sfr_pkg::*;
	localparam int PW = 600;
	localparam int LW = 20;
	// Own code for the configuration rewrite after rescue
	localparam logic [7:0] CFG_WRITE = 8'hc3;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic supply_ok = 1'b0, boot_xip = 1'b1, boot_proto_dual = 1'b1;
	logic array_busy = 1'b0, deep_power_down = 1'b0;
	logic rescue_start = 1'b0, hw_reset_start = 1'b0, cmd_start = 1'b0;
	logic [7:0] cmd_byte = 8'h00;
	logic poc, ready, in_xip, proto_ext, wel, wip, lwb, ldb, cmd_strobe, rescue_done, busy, done;
	logic [7:0] last_cmd;
	int error_cnt = 0, n_tests = 0;
	int fr_cnt = 0, low_run = 0, last_low = 0, strobes = 0, cyc = 0;
	logic [7:0] fr_byte = 8'h00;
	logic fr_ones = 1'b1, sclk_q = 1'b0, sel_q = 1'b1;
	int fr_q[$];
	logic [7:0] by_q[$];
	logic ones_q[$];
	sfr_link_if link();
	sfr_flash_end #(.POWER_WAIT_CYC(PW), .LONG_WAIT_CYC(LW)) sfr_flash_end_i (.sys_clk(sys_clk),
		.rstn(rstn), .link(link), .supply_ok(supply_ok), .boot_xip(boot_xip),
		.boot_proto_dual(boot_proto_dual), .array_busy(array_busy),
		.deep_power_down(deep_power_down), .power_on_complete(poc), .ready(ready),
		.in_xip(in_xip), .proto_ext(proto_ext), .write_enable_latch(wel),
		.write_in_progress(wip), .lock_write_bit(lwb), .lock_down_bit(ldb),
		.last_cmd(last_cmd), .cmd_strobe(cmd_strobe), .rescue_done(rescue_done));
	sfr_host_end #(.CLK_DIV(4)) sfr_host_end_i (.sys_clk(sys_clk), .rstn(rstn), .link(link),
		.supply_ok(supply_ok), .rescue_start(rescue_start), .hw_reset_start(hw_reset_start),
		.cmd_start(cmd_start), .cmd_byte(cmd_byte), .busy(busy), .done(done));
	sfr_link_asserts sfr_link_asserts_i (.sys_clk(sys_clk), .rstn(rstn), .supply_ok(supply_ok),
		.sclk(link.sclk), .sel_n(link.sel_n), .hw_reset_n(link.hw_reset_n),
		.io_line_zero(link.io_line_zero), .io_line_three_hold(link.io_line_three_hold),
		.io_line_one(link.io_line_one), .io_line_one_oe(link.io_line_one_oe));
	always #12.5 sys_clk = ~sys_clk;
	// Wire monitor on the falling edge, where the link has settled and tasks do not race it
	always @(negedge sys_clk) begin
		cyc++;
		if (!link.sel_n && link.sclk && !sclk_q) begin
			fr_cnt++;
			fr_byte = {fr_byte[6:0], link.io_line_zero};
			fr_ones = fr_ones & link.io_line_zero;
		end
		if (link.sel_n && !sel_q) begin
			fr_q.push_back(fr_cnt);
			by_q.push_back(fr_byte);
			ones_q.push_back(fr_ones);
		end
		if (link.sel_n) begin
			fr_cnt = 0;
			fr_ones = 1'b1;
		end
		sel_q = link.sel_n;
		sclk_q = link.sclk;
		if (cmd_strobe === 1'b1) strobes++;
		if (ready === 1'b0 && poc === 1'b1) low_run++;
		else if (low_run != 0) begin
			last_low = low_run;
			low_run = 0;
		end
	end
	task automatic chk_bit(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk_bit
	task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk_val
	task automatic chk_range(input int g, input int lo, input int hi);
		n_tests++;
		if (g < lo || g > hi) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h to %h", $time, g, lo, hi);
		end
	endtask : chk_range
	// One host request, waiting a bounded time for its done pulse
	task automatic host_op(input int k, input logic [7:0] b);
		int i;
		fr_q.delete();
		by_q.delete();
		ones_q.delete();
		cmd_byte <= b;
		rescue_start <= (k == 0);
		hw_reset_start <= (k == 1);
		cmd_start <= (k == 2);
		@(posedge sys_clk);
		rescue_start <= 1'b0;
		hw_reset_start <= 1'b0;
		cmd_start <= 1'b0;
		for (i = 0; i < 2000 && done !== 1'b1; i++) @(posedge sys_clk);
		chk_bit(done, 1'b1);
		repeat (4) @(posedge sys_clk);
	endtask : host_op
	// Command byte: MSB first, eight clocks, strobe only if accepted
	task automatic t_cmd(input logic [7:0] b, input int exp_strobe);
		int s0;
		s0 = strobes;
		host_op(2, b);
		chk_range(fr_q.pop_back(), 8, 8);
		chk_val(by_q.pop_back(), b);
		chk_range(strobes - s0, exp_strobe, exp_strobe);
		if (exp_strobe == 1) chk_val(last_cmd, b);
		$display("test command %h done", b);
	endtask : t_cmd
	// Supply low: host refuses, nothing reaches the wire
	task automatic t_refused();
		fr_q.delete();
		cmd_byte <= CMD_READ_STATUS;
		cmd_start <= 1'b1;
		@(posedge sys_clk);
		cmd_start <= 1'b0;
		repeat (20) @(posedge sys_clk);
		chk_bit(busy, 1'b0);
		chk_range(fr_q.size(), 0, 0);
		chk_bit(poc, 1'b0);
		chk_bit(ready, 1'b0);
		chk_bit(link.io_line_one_oe, 1'b0);
		chk_bit(link.io_line_one, 1'b0);
		$display("test refused done");
	endtask : t_refused
	task automatic t_power_up();
		int c0;
		int i;
		supply_ok <= 1'b1;
		c0 = cyc;
		repeat (6) @(posedge sys_clk);
		t_cmd(CMD_RESET_ENABLE, 0);
		t_cmd(CMD_READ_STATUS, 1);
		t_cmd(CMD_READ_FLAG_STATUS, 1);
		chk_bit(poc, 1'b0);
		for (i = 0; i < 2 * PW && poc !== 1'b1; i++) @(posedge sys_clk);
		chk_range(cyc - c0, PW, PW + 5);
		chk_bit(wel, 1'b0);
		chk_bit(wip, 1'b0);
		chk_bit(lwb, 1'b0);
		chk_bit(ldb, 1'b0);
		chk_bit(in_xip, 1'b1);
		chk_bit(proto_ext, 1'b0);
		$display("test power up done");
	endtask : t_power_up
	task automatic t_rescue();
		host_op(0, 8'h00);
		chk_range(fr_q.size(), 4, 4);
		chk_range(fr_q.pop_front(), 7, 7);
		chk_range(fr_q.pop_front(), 13, 13);
		chk_range(fr_q.pop_front(), 25, 25);
		chk_range(fr_q.pop_front(), 8, 8);
		foreach (ones_q[i]) chk_bit(ones_q[i], 1'b1);
		chk_bit(proto_ext, 1'b1);
		chk_bit(in_xip, 1'b0);
		chk_bit(rescue_done, 1'b1);
		// Host then rewrites the configuration; it must be accepted
		t_cmd(CFG_WRITE, 1);
		$display("test rescue done");
	endtask : t_rescue
	// Ready dip after a reset pin pulse, short or long recovery
	task automatic t_hw_reset(input logic slow, input int lo, input int hi);
		array_busy <= slow;
		last_low = 0;
		host_op(1, 8'h00);
		repeat (LW + 10) @(posedge sys_clk);
		chk_range(last_low, lo, hi);
		array_busy <= 1'b0;
		$display("test hardware reset done");
	endtask : t_hw_reset
	// Reset-enable then reset-memory, short or long recovery
	task automatic t_soft_reset(input logic dpd, input int lo, input int hi);
		deep_power_down <= dpd;
		t_cmd(CMD_RESET_ENABLE, 1);
		last_low = 0;
		t_cmd(CMD_RESET_MEMORY, 1);
		repeat (LW + 10) @(posedge sys_clk);
		chk_range(last_low, lo, hi);
		deep_power_down <= 1'b0;
		$display("test soft reset done");
	endtask : t_soft_reset
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	initial begin
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		t_refused();
		t_power_up();
		t_rescue();
		t_hw_reset(1'b0, 1, LW - 8);
		t_hw_reset(1'b1, LW, LW + 8);
		t_soft_reset(1'b0, 1, 3);
		t_soft_reset(1'b1, LW, LW + 3);
		// Supply drop: back to power-on reset
		supply_ok <= 1'b0;
		repeat (5) @(posedge sys_clk);
		chk_bit(rescue_done, 1'b0);
		t_refused();
		finish_test();
	end
	// Watchdog well beyond the expected run of some 1900 cycles
	initial begin
		#400000;
		error_cnt++;
		finish_test();
	end
endmodule : tb_top
